// *** common/spi_port_pkg.sv ***
`default_nettype none
package spi_port_pkg;

    // Register locations
    localparam logic [7:0] SFR_IRQ_FLAG = 8'hF8;
    localparam logic [7:0] SFR_CMD = 8'hFD;
    localparam logic [15:0] IO_IRQ_EN = 16'h2701;
    localparam logic [15:0] IO_STATUS = 16'h2708;
    localparam logic [15:0] IO_CONFIG = 16'h270C;

    // Field positions
    localparam int IRQ_FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 7;
    localparam int PORT_EN_BIT = 4;
    localparam int GUARD_BIT = 3;

    // Reset values
    localparam logic PORT_EN_RST = 1'h1;
    localparam logic GUARD_RST = 1'h0;
    localparam logic IRQ_EN_RST = 1'h0;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] CMD_RST = 8'h00;

    // Guarded write window
    localparam logic [15:0] GUARD_LO = 16'h0400;
    localparam logic [15:0] GUARD_HI = 16'h040F;

    // Quiet command and short count
    localparam logic [6:0] QUIET_CMD_LOW = 7'h00;
    localparam logic [2:0] SHORT_COUNT = 3'h7;

    // Byte slots
    localparam logic [2:0] SLOT_ADDR_LO = 3'h1;
    localparam logic [2:0] SLOT_CMD = 3'h2;
    localparam logic [2:0] SLOT_STATUS = 3'h3;
    localparam logic [2:0] SLOT_DATA = 3'h4;

    // Link timing
    localparam int LINK_PERIOD_NS = 400;
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS / 2;

    typedef struct packed {
        logic ready_err;
        logic rd_par;
        logic wr_par;
        logic [2:0] count;
        logic flash_mode;
        logic flash_ready;
    } status_s;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic sfr;
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mpu_req_s;

endpackage : spi_port_pkg
`default_nettype wire

// *** hw/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels in and out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("WIDTH below one");
        end
    end

    // First stage is read by the second stage only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : pin_sync
`default_nettype wire

// *** hw/spi_slave_transaction_port.sv ***
// Summary of operation
// - Guard on: memory writes blocked outside 0x400 to 0x40F.
// - Guard bit is config byte bit 3, resets to off.
// - Guard on: command register still updates; writes inside the window still land.
// - One-byte transaction always loads command register and interrupts.
// - Multi-byte: 16-bit address, command, status, then data bytes.
// - Command top bit set reads from address, incrementing per byte.
// - Read end loads command and interrupts unless command is 0x80.
// - Command top bit clear writes at address, incrementing per byte.
// - Write end loads command and interrupts unless command is 0x00.
// - Status reports previous transaction, read-only at 0x2708, resets zero.
// - Status bit 7: device was not ready for the access.
// - Status bit 6: parity of bytes host read, status excluded.
// - Status bit 5: parity of bytes host wrote, address and command in.
// - Status bits 4-2: low count of status and data bytes; short transactions give 111.
// - Status bit 1: flash mode, zero while test pin is low.
// - Status bit 0: flash ready for another write in flash mode.
// - Interrupt flag set by hardware, cleared only by writing zero.
// - Interrupt enable bit gates the interrupt, resets to zero.
// - Port enable bit, set at reset, connects port to its pins.
// - Command register holds last accepted command byte, read-only.
// - Select high: port held idle, output undriven, clock ignored.
// - Transaction starts at first serial clock rise after select falls.
// - Status error bit also flags transaction not ending on byte boundary.
`timescale 1ns/1ps
`default_nettype none
module spi_slave_transaction_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host pins
    input wire logic host_select_n,
    input wire logic host_serial_clock_in,
    input wire logic host_to_device_line,
    output logic device_to_host_line,
    output logic device_to_host_oe,
    output logic port_pins_enable,
    // Flash mode and test pin
    input wire logic test_pin,
    input wire logic flash_programming_mode,
    input wire logic flash_ready,
    // Processor register access
    input wire spi_port_pkg::mpu_req_s mpu_req,
    output logic [7:0] mpu_rdata,
    // Memory access
    output logic mem_req_valid,
    output spi_port_pkg::mem_req_s mem_req,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    // Interrupt to processor
    output logic port_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [3:0] pins_s;
    logic sel_n_s;
    logic sck_s;
    logic sdi_s;
    logic test_s;
    logic sck_prev_q;
    logic sel_prev_q;
    logic sel;
    logic sck_rise;
    logic sck_fall;
    logic sel_end;

    pin_sync #(.WIDTH(4), .RESET_VAL(4'h8)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({host_select_n, host_serial_clock_in,
                   host_to_device_line, test_pin}),
        .sync_out(pins_s)
    );

    assign sel_n_s = pins_s[3];
    assign sck_s = pins_s[2];
    assign sdi_s = pins_s[1];
    assign test_s = pins_s[0];

    logic port_en_q;
    logic guard_q;
    logic irq_en_q;
    logic irq_flag_q;
    logic [7:0] cmd_q;
    spi_port_pkg::status_s status_q;

    // Disabled port behaves as if select were held high
    assign sel = !sel_n_s && port_en_q;
    assign port_pins_enable = port_en_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_prev_q <= 1'h0;
            sel_prev_q <= 1'h0;
        end else begin
            sck_prev_q <= sck_s;
            sel_prev_q <= sel;
        end
    end

    assign sck_rise = sel && sck_s && !sck_prev_q;
    assign sck_fall = sel && !sck_s && sck_prev_q;
    assign sel_end = sel_prev_q && !sel;

    ////////////////////////////////////////////////////////////////////////
    // Receive shifter and byte slots

    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [2:0] slot_q;
    logic [2:0] data_cnt_q;
    logic [7:0] first_q;
    logic [15:0] addr_q;
    logic [7:0] txn_cmd_q;
    logic wr_par_q;
    logic rd_par_q;
    logic ready_err_q;
    logic [7:0] rx_byte;
    logic byte_done;
    logic is_read;

    assign rx_byte = {rx_q[6:0], sdi_s};
    assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
    assign is_read = txn_cmd_q[7];

    // Counters restart while select is high
    always_ff @(posedge clk) begin
        if (!rst_n || !sel) begin
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
            slot_q <= 3'h0;
            data_cnt_q <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_q <= rx_byte;
            if (bit_cnt_q == 3'h7) begin
                if (slot_q != spi_port_pkg::SLOT_DATA) begin
                    slot_q <= slot_q + 3'h1;
                end
                if (slot_q >= spi_port_pkg::SLOT_STATUS) begin
                    data_cnt_q <= data_cnt_q + 3'h1;
                end
            end
        end
    end

    // Header capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_q <= 8'h00;
            txn_cmd_q <= 8'h00;
        end else if (byte_done) begin
            case (slot_q)
                3'h0: first_q <= rx_byte;
                spi_port_pkg::SLOT_CMD: txn_cmd_q <= rx_byte;
                default: first_q <= first_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory accesses

    logic read_fetch;
    logic write_store;
    logic wr_allowed;
    logic pending_q;
    logic [7:0] rd_buf_q;
    logic rd_valid_q;
    logic tx_load;
    logic tx_data_slot;

    function automatic logic in_window(input logic [15:0] a);
        in_window = (a >= spi_port_pkg::GUARD_LO)
                    && (a <= spi_port_pkg::GUARD_HI);
    endfunction : in_window

    // Fetch ahead so data is ready before the next byte slot starts
    assign read_fetch = byte_done
                        && (slot_q == spi_port_pkg::SLOT_CMD ? rx_byte[7]
                            : tx_data_slot && is_read);
    assign write_store = byte_done && !is_read
                         && (slot_q == spi_port_pkg::SLOT_DATA);
    assign wr_allowed = !guard_q || in_window(addr_q);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_q <= 16'h0000;
        end else if (byte_done && slot_q == spi_port_pkg::SLOT_ADDR_LO) begin
            addr_q <= {first_q, rx_byte};
        end else if (read_fetch || write_store) begin
            addr_q <= addr_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_req_valid <= 1'h0;
            mem_req <= '0;
        end else begin
            mem_req_valid <= read_fetch || (write_store && wr_allowed);
            if (read_fetch) begin
                mem_req <= '{we: 1'h0, addr: addr_q, wdata: 8'h00};
            end else if (write_store) begin
                mem_req <= '{we: 1'h1, addr: addr_q, wdata: rx_byte};
            end
        end
    end

    // Read data returns on acknowledge; an unacked access is a ready error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending_q <= 1'h0;
            rd_buf_q <= 8'h00;
            rd_valid_q <= 1'h0;
        end else begin
            if (mem_req_valid) begin
                pending_q <= 1'h1;
            end else if (mem_ack) begin
                pending_q <= 1'h0;
            end
            if (mem_ack && pending_q && !mem_req.we) begin
                rd_buf_q <= mem_rdata;
                rd_valid_q <= 1'h1;
            end else if ((tx_load && tx_data_slot) || !sel) begin
                rd_valid_q <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit shifter

    logic [7:0] tx_q;

    assign tx_load = sck_fall && (bit_cnt_q == 3'h0)
                     && (slot_q >= spi_port_pkg::SLOT_STATUS);
    assign tx_data_slot = slot_q == spi_port_pkg::SLOT_DATA;

    // Driven in status and read data slots
    always_ff @(posedge clk) begin
        if (!rst_n || !sel) begin
            tx_q <= 8'h00;
            device_to_host_oe <= 1'h0;
        end else if (tx_load) begin
            tx_q <= tx_data_slot ? rd_buf_q : status_q;
            device_to_host_oe <= !tx_data_slot || is_read;
        end else if (sck_fall) begin
            tx_q <= {tx_q[6:0], 1'h0};
        end
    end

    assign device_to_host_line = tx_q[7];

    // Parities and ready error
    always_ff @(posedge clk) begin
        if (!rst_n || (!sel && !sel_end)) begin
            wr_par_q <= 1'h0;
            rd_par_q <= 1'h0;
            ready_err_q <= 1'h0;
        end else begin
            if (byte_done && (slot_q <= spi_port_pkg::SLOT_CMD
                              || !is_read)) begin
                wr_par_q <= wr_par_q ^ (^rx_byte);
            end
            if (sck_rise && tx_data_slot && is_read) begin
                rd_par_q <= rd_par_q ^ tx_q[7];
            end
            if (tx_load && tx_data_slot && is_read) begin
                if (!rd_valid_q) begin
                    ready_err_q <= 1'h1;
                end
            end
            if (mem_req_valid && pending_q && !mem_ack) begin
                ready_err_q <= 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // End of transaction

    logic single_byte;
    logic multi_byte;
    logic cmd_event;

    assign single_byte = (slot_q == 3'h1) && (bit_cnt_q == 3'h0);
    assign multi_byte = slot_q >= spi_port_pkg::SLOT_STATUS;
    assign cmd_event = sel_end && (single_byte
        || (multi_byte
            && txn_cmd_q[6:0] != spi_port_pkg::QUIET_CMD_LOW));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= spi_port_pkg::STATUS_RST;
        end else begin
            if (sel_end) begin
                status_q.ready_err <= ready_err_q
                                      || (bit_cnt_q != 3'h0);
                status_q.rd_par <= rd_par_q;
                status_q.wr_par <= wr_par_q;
                status_q.count <= (slot_q < spi_port_pkg::SLOT_DATA)
                                  ? spi_port_pkg::SHORT_COUNT
                                  : data_cnt_q;
            end
            status_q.flash_mode <= flash_programming_mode && test_s;
            status_q.flash_ready <= flash_programming_mode
                                    && test_s && flash_ready;
        end
    end

    // Command register keeps its value across idle periods
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_q <= spi_port_pkg::CMD_RST;
        end else if (cmd_event) begin
            cmd_q <= single_byte ? first_q : txn_cmd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Processor registers

    logic flag_clear;

    assign flag_clear = mpu_req.wr && mpu_req.sfr
                        && mpu_req.addr[7:0] == spi_port_pkg::SFR_IRQ_FLAG
                        && !mpu_req.wdata[spi_port_pkg::IRQ_FLAG_BIT];

    // A new event in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_flag_q <= 1'h0;
        end else if (cmd_event) begin
            irq_flag_q <= 1'h1;
        end else if (flag_clear) begin
            irq_flag_q <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_en_q <= spi_port_pkg::PORT_EN_RST;
            guard_q <= spi_port_pkg::GUARD_RST;
            irq_en_q <= spi_port_pkg::IRQ_EN_RST;
        end else if (mpu_req.wr && !mpu_req.sfr) begin
            if (mpu_req.addr == spi_port_pkg::IO_CONFIG) begin
                port_en_q <= mpu_req.wdata[spi_port_pkg::PORT_EN_BIT];
                guard_q <= mpu_req.wdata[spi_port_pkg::GUARD_BIT];
            end
            if (mpu_req.addr == spi_port_pkg::IO_IRQ_EN) begin
                irq_en_q <= mpu_req.wdata[spi_port_pkg::IRQ_EN_BIT];
            end
        end
    end

    assign port_irq = irq_flag_q && irq_en_q;

    // Read data is registered; unmapped locations read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mpu_rdata <= 8'h00;
        end else if (mpu_req.rd) begin
            mpu_rdata <= 8'h00;
            if (mpu_req.sfr) begin
                case (mpu_req.addr[7:0])
                    spi_port_pkg::SFR_CMD: mpu_rdata <= cmd_q;
                    spi_port_pkg::SFR_IRQ_FLAG:
                        mpu_rdata[spi_port_pkg::IRQ_FLAG_BIT] <= irq_flag_q;
                    default: mpu_rdata <= 8'h00;
                endcase
            end else begin
                case (mpu_req.addr)
                    spi_port_pkg::IO_STATUS: mpu_rdata <= status_q;
                    spi_port_pkg::IO_IRQ_EN:
                        mpu_rdata[spi_port_pkg::IRQ_EN_BIT] <= irq_en_q;
                    spi_port_pkg::IO_CONFIG: begin
                        mpu_rdata[spi_port_pkg::PORT_EN_BIT] <= port_en_q;
                        mpu_rdata[spi_port_pkg::GUARD_BIT] <= guard_q;
                    end
                    default: mpu_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule : spi_slave_transaction_port
`default_nettype wire

// *** test/spi_port_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_port_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host pins
    input wire logic host_select_n,
    input wire logic device_to_host_oe,
    input wire logic port_pins_enable,
    // Processor and memory
    input wire spi_port_pkg::mpu_req_s mpu_req,
    input wire logic mem_req_valid,
    input wire spi_port_pkg::mem_req_s mem_req,
    input wire logic port_irq
);
    logic cfg_wr;
    logic guard_q;
    logic en_q;
    logic ien_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    assign cfg_wr = mpu_req.wr && !mpu_req.sfr &&
        mpu_req.addr == spi_port_pkg::IO_CONFIG;
    // Control bit shadows
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            guard_q <= spi_port_pkg::GUARD_RST;
            en_q <= spi_port_pkg::PORT_EN_RST;
            ien_q <= spi_port_pkg::IRQ_EN_RST;
        end else if (cfg_wr) begin
            guard_q <= mpu_req.wdata[spi_port_pkg::GUARD_BIT];
            en_q <= mpu_req.wdata[spi_port_pkg::PORT_EN_BIT];
        end else if (mpu_req.wr && !mpu_req.sfr &&
                     mpu_req.addr == spi_port_pkg::IO_IRQ_EN) begin
            ien_q <= mpu_req.wdata[spi_port_pkg::IRQ_EN_BIT];
        end
    end
    // Sync and output register delay
    sequence s_sel_idle;
        host_select_n [*6];
    endsequence
    a_idle_no_drive: assert property (s_sel_idle
        |-> !device_to_host_oe) else $error("idle drive");
    a_idle_no_mem: assert property (s_sel_idle
        |-> !mem_req_valid) else $error("idle access");
    a_pins_follow: assert property (cfg_wr
        |=> port_pins_enable == $past(mpu_req.wdata[4]))
        else $error("pin enable wrong");
    a_guard_window: assert property (
        mem_req_valid && mem_req.we && guard_q
        |-> mem_req.addr >= spi_port_pkg::GUARD_LO &&
            mem_req.addr <= spi_port_pkg::GUARD_HI)
        else $error("guard breached");
    a_off_quiet: assert property (!en_q && $past(!en_q)
        |-> !device_to_host_oe && !mem_req_valid)
        else $error("disabled port is active");
    a_irq_gate: assert property (port_irq |-> ien_q)
        else $error("irq not gated");
    a_irq_at_end: assert property ($rose(port_irq)
        |-> $past(mpu_req.wr) || (host_select_n && $past(host_select_n, 2)))
        else $error("early irq");
    a_irq_clear: assert property ($fell(port_irq)
        |-> $past(mpu_req.wr)) else $error("irq dropped");
endmodule : spi_port_properties
bind spi_slave_transaction_port spi_port_properties spi_port_properties_i (
    .clk(clk), .rst_n(rst_n), .host_select_n(host_select_n),
    .device_to_host_oe(device_to_host_oe),
    .port_pins_enable(port_pins_enable), .mpu_req(mpu_req),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .port_irq(port_irq)
);
`default_nettype wire

// *** test/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk,
    // Link pins
    output logic host_select_n,
    output logic host_serial_clock_in,
    output logic host_to_device_line,
    input wire logic device_to_host_line
);
    logic [7:0] tx_b [0:31];
    logic [7:0] rx_b [0:31];
    initial begin
        host_select_n = 1'b1;
        host_serial_clock_in = 1'b0;
        host_to_device_line = 1'b0;
    end
    // Mode 0; clock low between frames
    task automatic frame(input int nbits);
        @(posedge clk);
        host_select_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            host_serial_clock_in <= 1'b0;
            host_to_device_line <= tx_b[i / 8][7 - i % 8];
            repeat (4) @(posedge clk);
            rx_b[i / 8] = {rx_b[i / 8][6:0], device_to_host_line};
            host_serial_clock_in <= 1'b1;
            repeat (4) @(posedge clk);
        end
        host_serial_clock_in <= 1'b0;
        repeat (4) @(posedge clk);
        host_select_n <= 1'b1;
        host_to_device_line <= ~host_to_device_line;
        repeat (16) @(posedge clk);
    endtask : frame
endmodule : host_model
`default_nettype wire

// *** test/spi_slave_transaction_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_slave_transaction_port_tb;
    logic clk, rst_n, sel_n, sck, sdi, sdo, oe, pins_en, test_pin;
    logic fl_mode, fl_rdy, mem_req_valid, mem_ack, port_irq, ien, guard;
    logic port_on, stall, exp_flag;
    logic [7:0] mpu_rdata, mem_rdata, exp_stat, exp_cmd, st_mask;
    logic [7:0] mem [0:2047];
    spi_port_pkg::mpu_req_s mpu_req;
    spi_port_pkg::mem_req_s mem_req, m_q;
    int n_mismatch, checked, m_cnt;
    spi_slave_transaction_port spi_slave_transaction_port_i (.clk(clk),
        .rst_n(rst_n), .host_select_n(sel_n), .host_serial_clock_in(sck),
        .host_to_device_line(sdi), .device_to_host_line(sdo),
        .device_to_host_oe(oe), .port_pins_enable(pins_en),
        .test_pin(test_pin), .flash_programming_mode(fl_mode),
        .flash_ready(fl_rdy), .mpu_req(mpu_req), .mpu_rdata(mpu_rdata),
        .mem_req_valid(mem_req_valid), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .port_irq(port_irq));
    host_model host_model_i (.clk(clk), .host_select_n(sel_n),
        .host_serial_clock_in(sck), .host_to_device_line(sdi),
        .device_to_host_line(sdo));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // One-clock memory; a stall answers too late on purpose
    always @(posedge clk) begin
        mem_ack <= m_cnt == 1 && !mem_req_valid;
        mem_rdata <= (m_cnt == 1) ? mem[m_q.addr[10:0]] : ~mem_rdata;
        if (m_cnt == 1 && m_q.we) mem[m_q.addr[10:0]] <= m_q.wdata;
        if (mem_req_valid) begin
            m_q <= mem_req;
            m_cnt <= stall ? 8 : 1;
        end else if (m_cnt > 0) begin
            m_cnt <= m_cnt - 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic mpu_wr(input logic s, input logic [15:0] a,
                          input logic [7:0] d);
        @(posedge clk);
        mpu_req <= '{sfr: s, addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        mpu_req.wr <= 1'b0;
    endtask : mpu_wr
    task automatic reg_chk(input logic s, input logic [15:0] a,
                           input logic [7:0] m, input logic [7:0] x);
        @(posedge clk);
        mpu_req <= '{sfr: s, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        mpu_req.rd <= 1'b0;
        @(posedge clk);
        check("register", mpu_rdata & m, x & m);
    endtask : reg_chk
    function automatic logic [7:0] stat_of(input int n, input logic wp,
                                           input logic rp, input logic er);
        logic [2:0] c;
        c = (n < 4) ? spi_port_pkg::SHORT_COUNT : 3'(n - 3);
        return {er, rp, wp, c, 2'h0};
    endfunction : stat_of
    task automatic txn(input int n, input logic [15:0] a,
                       input logic [7:0] c, input int xbits);
        logic [7:0] old [0:31];
        logic wp;
        logic rp;
        logic win;
        wp = 1'b0;
        rp = 1'b0;
        host_model_i.tx_b[0] = (n == 1) ? c : a[15:8];
        host_model_i.tx_b[1] = a[7:0];
        host_model_i.tx_b[2] = c;
        for (int i = 0; i <= n; i++) begin
            if (i > 2) begin
                host_model_i.tx_b[i] = (i > 3 && !c[7]) ? 8'($urandom) : 8'h00;
                old[i] = mem[11'(a + i - 4)];
            end
            if (i < n) wp = wp ^ (^host_model_i.tx_b[i]);
        end
        host_model_i.frame(8 * n + xbits);
        if (port_on && n >= 4) check("status",
            host_model_i.rx_b[3] & st_mask, exp_stat & st_mask);
        for (int i = 4; i <= n; i++) begin
            win = (a + i - 4 >= spi_port_pkg::GUARD_LO) &&
                (a + i - 4 <= spi_port_pkg::GUARD_HI);
            if (c[7] && i < n) begin
                rp = rp ^ (^mem[11'(a + i - 4)]);
                if (!stall && port_on) check("read",
                    host_model_i.rx_b[i], mem[11'(a + i - 4)]);
            end else if (!c[7]) begin
                check("memory", mem[11'(a + i - 4)],
                    (port_on && i < n && (!guard || win)) ?
                    host_model_i.tx_b[i] : old[i]);
            end
        end
        if (port_on) begin
            if (n == 1 || (n >= 3 && c[6:0] != spi_port_pkg::QUIET_CMD_LOW))
            begin
                exp_cmd = c;
                exp_flag = 1'b1;
            end
            exp_stat = stat_of(n, wp, rp, stall || xbits != 0);
            st_mask = (stall || xbits != 0) ? 8'h80 : 8'hFF;
        end
        reg_chk(1'b1, spi_port_pkg::SFR_CMD, 8'hFF, exp_cmd);
        reg_chk(1'b1, spi_port_pkg::SFR_IRQ_FLAG, 8'h80, {exp_flag, 7'h0});
        check("irq", {7'h0, port_irq}, {7'h0, exp_flag & ien});
    endtask : txn
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        $display("Error timeout");
        summarize();
    end
    initial begin
        void'($urandom(5820));
        {rst_n, test_pin, ien, guard, stall, exp_flag} = '0;
        {fl_mode, fl_rdy, port_on} = 3'h7;
        mpu_req = '0;
        exp_stat = spi_port_pkg::STATUS_RST;
        exp_cmd = spi_port_pkg::CMD_RST;
        st_mask = 8'hFF;
        for (int i = 0; i < 2048; i++) mem[i] = 8'($urandom);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_chk(1'b0, spi_port_pkg::IO_STATUS, 8'hFF, 8'h00);
        reg_chk(1'b0, spi_port_pkg::IO_CONFIG, 8'h18, 8'h10);
        reg_chk(1'b0, spi_port_pkg::IO_IRQ_EN, 8'h80, 8'h00);
        check("pins", {7'h0, pins_en}, 8'h01);
        $display("test reset done");
        mpu_wr(1'b0, spi_port_pkg::IO_IRQ_EN, 8'h80);
        ien = 1'b1;
        txn(1, 16'h0000, 8'h00, 0);
        txn(1, 16'h0000, 8'h80, 0);
        txn(6, 16'h0100, 8'h00, 0);
        txn(6, 16'h0100, 8'h80, 0);
        mpu_wr(1'b1, spi_port_pkg::SFR_IRQ_FLAG, 8'h00);
        exp_flag = 1'b0;
        txn(2, 16'h0100, 8'h7F, 0);
        $display("test commands done");
        for (int k = 0; k < 10; k++) begin
            txn($urandom_range(12, 1), 16'($urandom_range(16'h3F0)),
                8'($urandom), 0);
        end
        $display("test random done");
        stall = 1'b1;
        txn(5, 16'h0120, 8'h80, 0);
        stall = 1'b0;
        txn(6, 16'h0130, 8'h00, 3);
        txn(4, 16'h0000, 8'h80, 0);
        $display("test errors done");
        mpu_wr(1'b0, spi_port_pkg::IO_CONFIG, 8'h18);
        guard = 1'b1;
        reg_chk(1'b0, spi_port_pkg::IO_CONFIG, 8'h18, 8'h18);
        txn(24, 16'h03FC, 8'h22, 0);
        txn(1, 16'h0000, 8'h5A, 0);
        mpu_wr(1'b0, spi_port_pkg::IO_CONFIG, 8'h00);
        guard = 1'b0;
        port_on = 1'b0;
        txn(6, 16'h0140, 8'h33, 0);
        check("pins", {7'h0, pins_en}, 8'h00);
        mpu_wr(1'b0, spi_port_pkg::IO_CONFIG, 8'h10);
        port_on = 1'b1;
        $display("test guard done");
        mpu_wr(1'b1, spi_port_pkg::SFR_CMD, ~exp_cmd);
        mpu_wr(1'b0, spi_port_pkg::IO_STATUS, 8'hFF);
        mpu_wr(1'b0, 16'h2709, 8'hFF);
        reg_chk(1'b1, spi_port_pkg::SFR_CMD, 8'hFF, exp_cmd);
        reg_chk(1'b0, spi_port_pkg::IO_STATUS, 8'hFF, exp_stat);
        reg_chk(1'b0, spi_port_pkg::IO_CONFIG, 8'h18, 8'h10);
        @(posedge clk);
        test_pin <= 1'b1;
        host_model_i.frame(8);
        reg_chk(1'b0, spi_port_pkg::IO_STATUS, 8'h03, 8'h03);
        @(posedge clk);
        fl_rdy <= 1'b0;
        host_model_i.frame(8);
        reg_chk(1'b0, spi_port_pkg::IO_STATUS, 8'h03, 8'h02);
        $display("test registers done");
        summarize();
    end
endmodule : spi_slave_transaction_port_tb
`default_nettype wire
